// *** include/tls_map.vh ***
`ifndef TLS_MAP_VH
`define TLS_MAP_VH

// Device type field of the select byte
`define TLS_TYPE_MEM 4'ha
`define TLS_TYPE_PROT 4'h6
`define TLS_TYPE_TS 4'h3

// Select-byte chip field and upper two chip-select pin levels for the reversible lock instructions
`define TLS_CS_SET_LOCK 3'h1
`define TLS_CS_CLEAR_LOCK 3'h3
`define TLS_PINS_SET_LOCK 2'h0
`define TLS_PINS_CLEAR_LOCK 2'h1

// Sensor register pointers
`define TLS_PTR_ALARM_HIGH 8'h02
`define TLS_PTR_ALARM_LOW 8'h03
`define TLS_PTR_CRITICAL 8'h04
`define TLS_PTR_MAKER 8'h06
`define TLS_PTR_PART_REV 8'h07

// Limit register layout and reset
`define TLS_LIMIT_MASK 16'h1ffc
`define TLS_LIMIT_RESET 16'h0000

// Memory layout
`define TLS_MEM_DEPTH 256
`define TLS_MEM_ERASED 8'hff
`define TLS_LOCK_BIT 7

// Bit count of one byte
`define TLS_BITS_BYTE 4'h8
`define TLS_BITS_LAST 4'h7

`endif

// *** sim/tb_thermal_limit_and_spd_slave.sv ***
`timescale 1ns/10ps
`include "tls_map.vh"
module tb_thermal_limit_and_spd_slave;
  // Arbitrary identity values
  localparam [15:0] MKR = 16'h5a5a;
  localparam [7:0] PRT = 8'h3c;
  localparam [6:0] REV = 7'h05;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] pins = 3'h0;
  logic hv = 1'b0;
  logic pkg = 1'b1;
  wire scl;
  wire m_oe;
  wire s_oe;
  wire sda = ~(m_oe | s_oe);
  int error_cnt = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  tls_master m (.scl(scl), .sda_oe(m_oe), .sda(sda));
  tls_slave #(.MAKER_CODE(MKR), .PART_CODE(PRT), .REV_CODE(REV)) tls_slave_inst (.CLK_SYS(clk),
    .SYS_RST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(s_oe), .CHIP_SELECT_BIT_LOW(pins[0]),
    .CHIP_SELECT_BIT_MID(pins[1]), .CHIP_SELECT_BIT_HIGH(pins[2]), .HIGH_VOLTAGE_LEVEL(hv),
    .PACKAGE_VARIANT(pkg));
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic pin_set(input logic [2:0] p, input logic h);
    @(posedge clk);
    #1;
    pins = p;
    hv = h;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] dv, input logic [23:0] b, input int n, output logic [3:0] a);
    a = 4'h0;
    m.cond(1'b1);
    m.put({dv, 1'b0}, a[3]);
    for (int i = 0; i < n; i++)
      m.put(b[23-8*i -: 8], a[2-i]);
    m.cond(1'b0);
  endtask
  task automatic rd(input logic [6:0] dv, input logic [7:0] ad, input int n, output logic [15:0] v);
    logic a;
    v = 16'h0000;
    m.cond(1'b1);
    m.put({dv, 1'b0}, a);
    m.put(ad, a);
    m.cond(1'b1);
    m.put({dv, 1'b1}, a);
    for (int i = 0; i < n; i++)
      m.get(i == n - 1, v[15-8*i -: 8]);
    m.cond(1'b0);
  endtask
  task automatic t_limits();
    logic [15:0] v;
    logic [3:0] a;
    logic [15:0] wv [3] = '{16'hffff, 16'h1e74, 16'h07c3};
    logic [15:0] ev [3] = '{16'h1ffc, 16'h1e74, 16'h07c0};
    for (int i = 0; i < 3; i++) begin
      rd({`TLS_TYPE_TS, pins}, 8'h02 + 8'(i), 2, v);
      chk("limit reset", 16'h0000, v);
      wr({`TLS_TYPE_TS, pins}, {8'h02 + 8'(i), wv[i]}, 3, a);
      chk("limit ack", 16'h000f, {12'h000, a});
    end
    for (int i = 0; i < 3; i++) begin
      rd({`TLS_TYPE_TS, pins}, 8'h02 + 8'(i), 2, v);
      chk("limit value", ev[i], v);
    end
  endtask
  task automatic t_ident();
    logic [15:0] v;
    logic [3:0] a;
    wr({`TLS_TYPE_TS, pins}, {`TLS_PTR_MAKER, 16'h0000}, 3, a);
    rd({`TLS_TYPE_TS, pins}, `TLS_PTR_MAKER, 2, v);
    chk("maker", MKR, v);
    rd({`TLS_TYPE_TS, pins}, `TLS_PTR_PART_REV, 2, v);
    chk("part rev", {PRT, REV, 1'b1}, v);
  endtask
  task automatic t_mem();
    logic [15:0] v;
    logic [3:0] a;
    wr({4'ha, pins}, 24'hff_5aa5, 3, a);
    chk("mem ack", 16'h000f, {12'h000, a});
    rd({4'ha, pins}, 8'hff, 2, v);
    chk("mem wrap", 16'h5aa5, v);
  endtask
  task automatic t_select();
    logic [15:0] v;
    logic [3:0] a;
    pin_set(3'h5, 1'b0);
    wr({4'ha, 3'h5}, 24'h40_3c00, 2, a);
    chk("cs match", 16'h000e, {12'h000, a});
    wr({4'ha, 3'h4}, 24'h40_c300, 2, a);
    chk("cs mismatch", 16'h0000, {12'h000, a});
    wr({4'hf, 3'h5}, 24'h40_c300, 2, a);
    chk("bad type", 16'h0000, {12'h000, a});
    rd({4'ha, 3'h5}, 8'h40, 1, v);
    chk("cs data", 16'h3c00, v);
    pin_set(3'h0, 1'b0);
  endtask
  task automatic t_lock();
    logic [15:0] v;
    logic [3:0] a;
    wr({4'ha, 3'h0}, 24'h7f_1100, 2, a);
    wr({4'h6, 3'h1}, 24'h00_0000, 2, a);
    chk("lock no hv", 16'h0000, {12'h000, a});
    pin_set(3'h0, 1'b1);
    wr({4'h6, 3'h1}, 24'h00_0000, 2, a);
    chk("set lock", 16'h000e, {12'h000, a});
    rd({4'h6, 3'h1}, 8'h00, 1, v);
    chk("lock state", 16'h0100, v);
    pin_set(3'h0, 1'b0);
    wr({4'ha, 3'h0}, 24'h7f_2200, 2, a);
    chk("locked ack", 16'h000c, {12'h000, a});
    wr({4'ha, 3'h0}, 24'h80_3300, 2, a);
    chk("open ack", 16'h000e, {12'h000, a});
    rd({4'ha, 3'h0}, 8'h7f, 2, v);
    chk("locked data", 16'h1133, v);
    pin_set(3'h2, 1'b1);
    wr({4'h6, 3'h3}, 24'h00_0000, 2, a);
    chk("clear lock", 16'h000e, {12'h000, a});
    pin_set(3'h0, 1'b0);
    wr({4'ha, 3'h0}, 24'h7f_2200, 2, a);
    rd({4'ha, 3'h0}, 8'h7f, 1, v);
    chk("free data", 16'h2200, v);
    wr({4'h6, 3'h0}, 24'h00_0000, 2, a);
    chk("perm lock", 16'h000e, {12'h000, a});
    wr({4'ha, 3'h0}, 24'h7f_4400, 2, a);
    chk("perm ack", 16'h000c, {12'h000, a});
    wr({4'h6, 3'h0}, 24'h00_0000, 2, a);
    chk("perm final", 16'h0000, {12'h000, a});
  endtask
  task automatic t_strap();
    logic [15:0] v;
    logic [3:0] a;
    @(posedge clk);
    #1;
    pkg = 1'b0;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    rd({`TLS_TYPE_TS, pins}, `TLS_PTR_PART_REV, 2, v);
    chk("strap low", {PRT, REV, 1'b0}, v);
    rd({`TLS_TYPE_TS, pins}, `TLS_PTR_CRITICAL, 2, v);
    chk("limit rearm", 16'h0000, v);
    wr({4'ha, 3'h0}, 24'h7f_6600, 2, a);
    chk("lock cleared", 16'h000e, {12'h000, a});
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_limits();
    t_ident();
    t_mem();
    t_select();
    t_lock();
    t_strap();
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule

// *** sim/tls_master.sv ***
`timescale 1ns/10ps
module tls_master (
  output logic scl,
  output logic sda_oe,
  input wire sda
);
  localparam realtime QTR = 31.25;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  task automatic clk_bit(input logic b, output logic r);
    sda_oe = ~b;
    #QTR;
    scl = 1'b1;
    #QTR;
    r = sda;
    #QTR;
    scl = 1'b0;
    #QTR;
  endtask
  task automatic cond(input logic f);
    sda_oe = ~f;
    #QTR;
    scl = 1'b1;
    #QTR;
    sda_oe = f;
    #QTR;
    scl = ~f;
    #QTR;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(b[i], r);
    clk_bit(1'b1, r);
    ack = ~r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      b[i] = r;
    end
    clk_bit(last, r);
  endtask
endmodule

// *** sim/tls_slave_asserts.sv ***
`timescale 1ns/10ps
module tls_slave_chk (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE
);
  logic scl_reg;
  logic sda_reg;
  logic [7:0] hi_reg;
  wire fall = scl_reg & ~SCL_IN;
  wire strt = SCL_IN & scl_reg & sda_reg & ~SDA_IN;
  wire stp = SCL_IN & scl_reg & ~sda_reg & SDA_IN;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (SYS_RST);
  always @(posedge CLK_SYS) begin
    scl_reg <= SCL_IN;
    sda_reg <= SDA_IN;
    hi_reg <= (SYS_RST || !SDA_OE) ? 8'h00 : hi_reg + {7'h00, hi_reg != 8'hff};
  end
  property p_od_low;
    SDA_OUT == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("data value not low");
  property p_chg_low;
    $changed(SDA_OE) |-> !SCL_IN;
  endproperty
  a_chg_low: assert property (p_chg_low) else $error("data moved with clock high");
  property p_chg_fall;
    $changed(SDA_OE) |-> $past(fall, 2) || $past(fall, 3) || $past(fall, 4) || $past(fall, 5);
  endproperty
  a_chg_fall: assert property (p_chg_fall) else $error("data moved off clock fall");
  property p_ack_stands;
    $rose(SDA_OE) |=> SDA_OE [*8];
  endproperty
  a_ack_stands: assert property (p_ack_stands) else $error("pull-down too short");
  property p_hold_bound;
    hi_reg < 8'h80;
  endproperty
  a_hold_bound: assert property (p_hold_bound) else $error("bus held too long");
  property p_start_quiet;
    strt |=> !SDA_OE [*8];
  endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("drive after start");
  property p_stop_idle;
    stp |-> !SDA_OE [*8];
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("drive after stop");
  property p_rise_stable;
    $rose(SCL_IN) |=> $stable(SDA_OE) [*4];
  endproperty
  a_rise_stable: assert property (p_rise_stable) else $error("data moved in high phase");
  cover property ($rose(SDA_OE));
  cover property (strt);
  cover property (stp);
endmodule
bind tls_slave tls_slave_chk tls_slave_chk_inst (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE));

// *** verilog/tls_mem.v ***
`timescale 1ns/10ps
`include "tls_map.vh"
module tls_mem (
  input wire clk,
  input wire rst,
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_addr,
  output wire [7:0] rd_data
);
  wire [8*`TLS_MEM_DEPTH-1:0] flat;
  genvar i;
  generate
    for (i = 0; i < `TLS_MEM_DEPTH; i = i + 1) begin : g_cell
      reg [7:0] cell_reg;
      always @(posedge clk) begin
        if (rst) begin
          cell_reg <= `TLS_MEM_ERASED;
        end else if (wr_en && (wr_addr == i[7:0])) begin
          cell_reg <= wr_data;
        end
      end
      assign flat[8*i+7:8*i] = cell_reg;
    end
  endgenerate
  assign rd_data = flat[{rd_addr, 3'b000} +: 8];
endmodule

// *** verilog/tls_slave.v ***
// Operation
// RULE_01: Limit registers hold 11-bit two's-complement temperature, quarter degree per step.
// RULE_02: Unused top three and bottom two limit bits read as zero.
// RULE_03: Three limit registers, upper, lower and critical, each at its own pointer.
// RULE_04: Limit registers are 16 bits, read/write, and reset to all zeros.
// RULE_05: Master turns interrupts off before altering alarm boundaries in operation.
// RULE_06: A 16-bit read-only maker identification register holds a fixed code.
// RULE_07: Read-only register gives part code in upper byte, revision in lower.
// RULE_08: Revision bit zero reflects package variant, one or zero.
// RULE_09: Memory is 256 bytes reached through the two-wire interface.
// RULE_10: Lower 128 bytes may be locked, permanently or reversibly, by command.
// RULE_11: Type field 1010 selects memory, 0110 selects lock settings.
// RULE_12: Select bits three to one must equal the chip-select pins.
// RULE_13: Unconnected chip-select pins count as zero through pull-downs.
// RULE_14: Set and clear lock instructions need the high voltage on the low pin.
// RULE_15: Device is slave only, all operations timed by master's serial clock.
// RULE_16: Transfer starts with START, select byte with direction bit, then acknowledge.
// RULE_17: On writes the device acknowledges in the ninth bit of each byte.
// RULE_18: On reads the master acknowledges each byte in the ninth bit.
// RULE_19: Master ends writes with STOP after ACK, reads after not-ACK.
// RULE_20: Select byte bit eight is one for read, zero for write.
// RULE_21: On a select mismatch, withhold acknowledge, release bus, go to standby.
// RULE_22: Writes to fixed-zero limit bits are ignored.
`timescale 1ns/10ps
`include "tls_map.vh"
module tls_slave #(
  // Arbitrary identification values
  parameter [15:0] MAKER_CODE = 16'h5a5a,
  parameter [7:0] PART_CODE = 8'h00,
  parameter [6:0] REV_CODE = 7'h00
) (
  input wire CLK_SYS,
  input wire SYS_RST,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire CHIP_SELECT_BIT_LOW,
  input wire CHIP_SELECT_BIT_MID,
  input wire CHIP_SELECT_BIT_HIGH,
  input wire HIGH_VOLTAGE_LEVEL,
  input wire PACKAGE_VARIANT
);
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_RX = 5'b00010;
  localparam [4:0] ST_RACK = 5'b00100;
  localparam [4:0] ST_TX = 5'b01000;
  localparam [4:0] ST_TACK = 5'b10000;

  localparam [2:0] TG_MEM = 3'b001;
  localparam [2:0] TG_TS = 3'b010;
  localparam [2:0] TG_PROT = 3'b100;

  // Pin synchronisers
  wire [6:0] sync_q;
  tls_sync #(
    .WIDTH(7)
  ) u_sync (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .din({PACKAGE_VARIANT, HIGH_VOLTAGE_LEVEL, CHIP_SELECT_BIT_HIGH,
          CHIP_SELECT_BIT_MID, CHIP_SELECT_BIT_LOW, SDA_IN, SCL_IN}),
    .dout(sync_q)
  );

  wire scl_s = sync_q[0];
  wire sda_s = sync_q[1];
  // RULE_13: floating pins zero
  wire [2:0] cs_pins = sync_q[4:2];
  wire hv_s = sync_q[5];
  wire pkg_s = sync_q[6];

  reg [4:0] state_reg;
  reg scl_d_reg;
  reg sda_d_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] byte_cnt_reg;
  reg [7:0] shift_reg;
  reg sda_oe_reg;
  reg ack_reg;
  reg mack_reg;
  reg rw_reg;
  reg [2:0] target_reg;
  reg [2:0] prot_op_reg;
  reg [7:0] ptr_reg;
  reg [7:0] ts_ptr_reg;
  reg lsb_reg;
  reg [7:0] hold_reg;
  reg [15:0] alarm_high_limit_reg;
  reg [15:0] alarm_low_limit_reg;
  reg [15:0] critical_limit_reg;
  reg soft_lock_reg;
  reg perm_lock_reg;
  reg pkg_reg;
  reg strap_taken_reg;
  reg mem_we_reg;
  reg [7:0] mem_waddr_reg;
  reg [7:0] mem_wdata_reg;
  wire [7:0] mem_rdata;

  // RULE_09: byte memory
  tls_mem u_mem (
    .clk(CLK_SYS),
    .rst(SYS_RST),
    .wr_en(mem_we_reg),
    .wr_addr(mem_waddr_reg),
    .wr_data(mem_wdata_reg),
    .rd_addr(ptr_reg),
    .rd_data(mem_rdata)
  );

  // RULE_15: serial clock edges
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  // RULE_16: start and stop
  wire start_det = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire stop_det = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  wire [3:0] sel_type = rx_byte[7:4];
  wire [2:0] sel_cs = rx_byte[3:1];
  // RULE_20: direction bit
  wire sel_rd = rx_byte[0];
  // RULE_12: chip field match
  wire cs_match = (sel_cs == cs_pins);
  // RULE_14: high voltage needed
  wire set_hit = hv_s & (cs_pins[2:1] == `TLS_PINS_SET_LOCK) & (sel_cs == `TLS_CS_SET_LOCK);
  wire clear_hit = hv_s & (cs_pins[2:1] == `TLS_PINS_CLEAR_LOCK) & (sel_cs == `TLS_CS_CLEAR_LOCK);
  wire perm_hit = ~hv_s & cs_match;
  wire locked = soft_lock_reg | perm_lock_reg;
  // RULE_01 RULE_02 RULE_22: field masked
  wire [15:0] limit_wdata = {hold_reg, rx_byte} & `TLS_LIMIT_MASK;

  // Sensor register read mux
  reg [15:0] ts_word;
  always @* begin
    case (ts_ptr_reg)
      // RULE_03: pointer selection
      `TLS_PTR_ALARM_HIGH: ts_word = alarm_high_limit_reg;
      `TLS_PTR_ALARM_LOW: ts_word = alarm_low_limit_reg;
      `TLS_PTR_CRITICAL: ts_word = critical_limit_reg;
      // RULE_06: maker code
      `TLS_PTR_MAKER: ts_word = MAKER_CODE;
      // RULE_07: part and revision
      `TLS_PTR_PART_REV: ts_word = {PART_CODE, REV_CODE, pkg_reg};
      default: ts_word = 16'h0000;
    endcase
  end

  // Byte to send
  reg [7:0] tx_byte;
  always @* begin
    case (target_reg)
      TG_MEM: tx_byte = mem_rdata;
      TG_TS: tx_byte = lsb_reg ? ts_word[7:0] : ts_word[15:8];
      TG_PROT: tx_byte = {7'h00, locked};
      default: tx_byte = 8'hff;
    endcase
  end

  // Loads a byte and drives its first bit
  task load_tx;
    begin
      shift_reg <= tx_byte;
      sda_oe_reg <= ~tx_byte[7];
      bit_cnt_reg <= 4'h1;
      state_reg <= ST_TX;
      if (target_reg == TG_MEM) begin
        ptr_reg <= ptr_reg + 8'h01;
      end
      if (target_reg == TG_TS) begin
        lsb_reg <= ~lsb_reg;
      end
    end
  endtask

  // Handles a fully received byte
  task take_byte;
    begin
      if (byte_cnt_reg == 2'h0) begin
        rw_reg <= sel_rd;
        lsb_reg <= 1'b0;
        prot_op_reg <= {set_hit, clear_hit, perm_hit};
        // RULE_11: type decode
        if (sel_type == `TLS_TYPE_MEM) begin
          target_reg <= TG_MEM;
          ack_reg <= cs_match;
        end else if (sel_type == `TLS_TYPE_TS) begin
          target_reg <= TG_TS;
          ack_reg <= cs_match;
        end else if (sel_type == `TLS_TYPE_PROT) begin
          target_reg <= TG_PROT;
          ack_reg <= ~perm_lock_reg & (set_hit | clear_hit | perm_hit);
        end else begin
          // RULE_21: mismatch withholds ack
          target_reg <= 3'b000;
          ack_reg <= 1'b0;
        end
      end else if (target_reg == TG_MEM) begin
        if (byte_cnt_reg == 2'h1) begin
          ptr_reg <= rx_byte;
          ack_reg <= 1'b1;
        end else if (locked && !ptr_reg[`TLS_LOCK_BIT]) begin
          // RULE_10: lower half locked
          ack_reg <= 1'b0;
        end else begin
          mem_we_reg <= 1'b1;
          mem_waddr_reg <= ptr_reg;
          mem_wdata_reg <= rx_byte;
          ptr_reg <= ptr_reg + 8'h01;
          ack_reg <= 1'b1;
        end
      end else if (target_reg == TG_TS) begin
        // One limit write per frame, later bytes refused
        ack_reg <= (byte_cnt_reg != 2'h3) || !lsb_reg;
        if (byte_cnt_reg == 2'h1) begin
          ts_ptr_reg <= rx_byte;
          lsb_reg <= 1'b0;
        end else if (byte_cnt_reg == 2'h2) begin
          hold_reg <= rx_byte;
        end else if (!lsb_reg) begin
          lsb_reg <= 1'b1;
          // RULE_04: limit write
          case (ts_ptr_reg)
            `TLS_PTR_ALARM_HIGH: alarm_high_limit_reg <= limit_wdata;
            `TLS_PTR_ALARM_LOW: alarm_low_limit_reg <= limit_wdata;
            `TLS_PTR_CRITICAL: critical_limit_reg <= limit_wdata;
            default: hold_reg <= hold_reg;
          endcase
        end
      end else begin
        ack_reg <= (byte_cnt_reg != 2'h3);
        if (byte_cnt_reg == 2'h2) begin
          // RULE_10: lock instructions
          if (prot_op_reg[2]) begin
            soft_lock_reg <= 1'b1;
          end else if (prot_op_reg[1]) begin
            soft_lock_reg <= 1'b0;
          end else if (prot_op_reg[0]) begin
            perm_lock_reg <= 1'b1;
          end
        end
      end
      if (byte_cnt_reg != 2'h3) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
    end
  endtask

  always @(posedge CLK_SYS) begin
    if (SYS_RST) begin
      state_reg <= ST_IDLE;
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      ack_reg <= 1'b0;
      mack_reg <= 1'b0;
      rw_reg <= 1'b0;
      target_reg <= 3'b000;
      prot_op_reg <= 3'b000;
      ptr_reg <= 8'h00;
      ts_ptr_reg <= 8'h00;
      lsb_reg <= 1'b0;
      hold_reg <= 8'h00;
      // RULE_04: zero at reset
      alarm_high_limit_reg <= `TLS_LIMIT_RESET;
      alarm_low_limit_reg <= `TLS_LIMIT_RESET;
      critical_limit_reg <= `TLS_LIMIT_RESET;
      soft_lock_reg <= 1'b0;
      perm_lock_reg <= 1'b0;
      pkg_reg <= 1'b0;
      strap_taken_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_waddr_reg <= 8'h00;
      mem_wdata_reg <= 8'h00;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      mem_we_reg <= 1'b0;
      strap_taken_reg <= 1'b1;
      // RULE_08: package strap capture
      if (!strap_taken_reg) begin
        pkg_reg <= pkg_s;
      end
      if (stop_det) begin
        state_reg <= ST_IDLE;
        sda_oe_reg <= 1'b0;
      end else if (start_det) begin
        state_reg <= ST_RX;
        bit_cnt_reg <= 4'h0;
        byte_cnt_reg <= 2'h0;
        sda_oe_reg <= 1'b0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sda_oe_reg <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise && (bit_cnt_reg != `TLS_BITS_BYTE)) begin
              shift_reg <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
              if (bit_cnt_reg == `TLS_BITS_LAST) begin
                take_byte;
              end
            end else if (scl_fall && (bit_cnt_reg == `TLS_BITS_BYTE)) begin
              // RULE_17: ninth-bit acknowledge
              sda_oe_reg <= ack_reg;
              state_reg <= ST_RACK;
            end
          end
          ST_RACK: begin
            if (scl_fall) begin
              sda_oe_reg <= 1'b0;
              bit_cnt_reg <= 4'h0;
              if (!ack_reg) begin
                // RULE_21: release and standby
                state_reg <= ST_IDLE;
              end else if (rw_reg) begin
                load_tx;
              end else begin
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == `TLS_BITS_BYTE) begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_TACK;
              end else begin
                sda_oe_reg <= ~shift_reg[6];
                shift_reg <= {shift_reg[6:0], 1'b0};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_TACK: begin
            // RULE_18: master acknowledge sampled
            if (scl_rise) begin
              mack_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_reg) begin
                load_tx;
              end else begin
                // RULE_19: not-ack ends read
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open-drain data pin
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_reg;
endmodule

// *** verilog/tls_sync.v ***
`timescale 1ns/10ps
module tls_sync #(
  parameter WIDTH = 7
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // Free-running so the pin level is valid at reset release
      always @(posedge clk) begin
        meta_reg <= din[i];
        sync_reg <= meta_reg;
      end
      assign dout[i] = sync_reg;
    end
  endgenerate
endmodule
